// File: ebtt_regs.vh
// register offsets, field positions and reset values of the break and trace trigger unit
`ifndef EBTT_REGS_VH
`define EBTT_REGS_VH

// apb byte offsets
`define EBTT_OFS_CTRL 8'h00
`define EBTT_OFS_STATUS 8'h04
`define EBTT_OFS_VALUE 8'h08
`define EBTT_OFS_MASK 8'h0C
`define EBTT_OFS_EV_SEL 8'h10
`define EBTT_OFS_EV_CFG 8'h14
`define EBTT_OFS_EV_START 8'h18
`define EBTT_OFS_EV_END 8'h1C
`define EBTT_OFS_CMD 8'h20
`define EBTT_OFS_TR_DEPTH 8'h24
`define EBTT_OFS_TR_DATA 8'h28
`define EBTT_OFS_TR_COUNT 8'h2C
`define EBTT_OFS_STK_SEL 8'h30
`define EBTT_OFS_STK_DATA 8'h34
`define EBTT_OFS_SP 8'h38

// control register fields
`define EBTT_CTRL_CODE_EN 0
`define EBTT_CTRL_DATA_EN 1
`define EBTT_CTRL_COND_TRACE 2
`define EBTT_CTRL_EXT_EN 3
`define EBTT_CTRL_EXT_RISE 4
`define EBTT_CTRL_WDT_EN 5
`define EBTT_CTRL_TROVF_EN 6
`define EBTT_CTRL_TIMER_EN 7
`define EBTT_CTRL_STACK_EN 8
`define EBTT_CTRL_PROBE_SEL 9
`define EBTT_CTRL_W 10
`define EBTT_CTRL_RESET 10'h000

// event definition fields
`define EBTT_EV_EN 0
`define EBTT_EV_DATA 1
`define EBTT_EV_TYPE_A 2
`define EBTT_EV_TYPE_B 3
`define EBTT_EV_TYPE_C 4
`define EBTT_EV_CFG_W 5
`define EBTT_EV_CFG_RESET 5'h00

// command register bits (write only, self clearing)
`define EBTT_CMD_RESUME 0
`define EBTT_CMD_HALT 1
`define EBTT_CMD_TR_CLEAR 2

// halt cause bits in the status register, above the halted bit
`define EBTT_CAUSE_CODE 0
`define EBTT_CAUSE_DATA 1
`define EBTT_CAUSE_EXT 2
`define EBTT_CAUSE_WDT 3
`define EBTT_CAUSE_TROVF 4
`define EBTT_CAUSE_TIMER 5
`define EBTT_CAUSE_STACK 6
`define EBTT_CAUSE_HOST 7
`define EBTT_CAUSE_W 8

// sizes
`define EBTT_NUM_EVENTS 256
`define EBTT_TRACE_DEPTH 4096
`define EBTT_TRACE_AW 12
`define EBTT_TRACE_W 32

`endif

// File: ebtt_trace_buf.v
// circular trace memory read back by depth from the newest record
`timescale 1ns/100ps
`default_nettype none
module ebtt_trace_buf #(
  parameter DEPTH = 4096,
  parameter AW = 12,
  parameter W = 32
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // record input
  input wire wr_en,
  input wire [W-1:0] wr_data,
  input wire clear,
  // depth read port, depth 1 is the newest record
  input wire [AW:0] rd_depth,
  output reg [W-1:0] rd_data,
  // fill state
  output reg [AW:0] count,
  output wire overflow
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  wire full;
  wire [AW-1:0] rd_addr;

  assign full = (count == DEPTH[AW:0]);
  // a write into a full buffer overwrites the oldest record
  assign overflow = wr_en & full;
  // depth of DEPTH wraps to wptr itself, which is the oldest entry when full
  assign rd_addr = wptr - rd_depth[AW-1:0];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wptr] <= wr_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      rd_data <= {W{1'b0}};
    end else begin
      rd_data <= mem[rd_addr];
      if (clear) begin
        wptr <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
      end else if (wr_en) begin
        wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
        if (!full) begin
          count <= count + {{AW{1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // ebtt_trace_buf
`default_nettype wire

// File: ebtt_trigger.v
// break and trace trigger unit of the emulator, with its apb register file
//
// Summary of operation
// - holds 256 event definitions: allocation, effect types, address range
// - event acts only with its own enable and its class global enable
// - code address event halts when pc lies in its range
// - code trace event records every instruction executed inside its range
// - data access event halts on any read or write in its range
// - data write event halts on any write in its range
// - data value event halts on write whose masked data equals masked value
// - one value register and one mask register serve all value events
// - one event may carry several effect types of its class at once
// - external break halts when enabled, on the selected rising or falling edge
// - watchdog overflow halts when its option is enabled
// - trace memory overflow halts when enabled
// - free running timer rollover halts when enabled
// - return stack overflow or underflow halts when enabled
// - global code enable gates code events, global data enable gates data events
// - with conditional tracing off every instruction is recorded
// - while halted host reads and writes return addresses and stack pointer
// - trace record: 16 bits pc and control, 8 alu, 8 bus or probes
// - trace memory keeps 4096 records read by depth from newest
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ebtt_regs.vh"
module ebtt_trigger #(
  parameter NUM_EVENTS = 256,
  parameter EV_SEL_W = 8,
  parameter PC_W = 12,
  parameter STK_W = 3
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // instruction boundary from the core
  input wire insn_valid,
  input wire [PC_W-1:0] insn_pc,
  input wire [7:0] insn_alu,
  input wire [7:0] insn_dbus,
  // data memory accesses from the core
  input wire dmem_rd,
  input wire dmem_wr,
  input wire [7:0] dmem_addr,
  input wire [7:0] dmem_wdata,
  // internal break sources, one-cycle pulses
  input wire wdt_overflow,
  input wire free_running_timer_overflow,
  input wire stack_overflow,
  input wire stack_underflow,
  // pins
  input wire ext_break,
  input wire [7:0] probe,
  // halt control to the core
  output reg core_halt,
  output reg [PC_W-1:0] halt_pc,
  // return stack access in the core
  output reg [STK_W-1:0] stk_index,
  input wire [PC_W-1:0] stk_rdata,
  output reg [PC_W-1:0] stk_wdata,
  output reg stk_we,
  input wire [STK_W-1:0] sp_rdata,
  output reg [STK_W-1:0] sp_wdata,
  output reg sp_we
);

  localparam TAW = `EBTT_TRACE_AW;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [`EBTT_CTRL_W-1:0] ctrl;
  reg [7:0] ref_value;
  reg [7:0] ref_mask;
  reg [EV_SEL_W-1:0] ev_sel;
  reg [`EBTT_EV_CFG_W-1:0] ev_cfg [0:NUM_EVENTS-1];
  reg [PC_W-1:0] ev_lo [0:NUM_EVENTS-1];
  reg [PC_W-1:0] ev_hi [0:NUM_EVENTS-1];
  reg [TAW:0] tr_depth;
  reg [`EBTT_CAUSE_W-1:0] cause;
  reg pending;
  reg ext_s1, ext_s2, ext_s3, ext_lvl;
  reg [7:0] probe_s1, probe_s2, probe_s3;
  integer k;

  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire code_en = ctrl[`EBTT_CTRL_CODE_EN];
  wire data_en = ctrl[`EBTT_CTRL_DATA_EN];
  wire cmd_wr = wr_acc & (paddr == `EBTT_OFS_CMD);
  wire resume = cmd_wr & pwdata[`EBTT_CMD_RESUME];
  wire host_halt = cmd_wr & pwdata[`EBTT_CMD_HALT];
  wire tr_clear = cmd_wr & pwdata[`EBTT_CMD_TR_CLEAR];
  wire [TAW:0] tr_count;
  wire [31:0] tr_rdata;
  wire tr_overflow;

  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // per event range comparators

  wire [NUM_EVENTS-1:0] code_brk;
  wire [NUM_EVENTS-1:0] trace_hit;
  wire [NUM_EVENTS-1:0] data_brk;
  // one shared value and mask pair for all value events
  wire value_match = ((dmem_wdata & ref_mask) == (ref_value & ref_mask));
  wire [PC_W-1:0] daddr = {{(PC_W-8){1'b0}}, dmem_addr};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi = gi + 1) begin : g_ev
      wire [`EBTT_EV_CFG_W-1:0] c = ev_cfg[gi];
      wire code_cls = c[`EBTT_EV_EN] & ~c[`EBTT_EV_DATA] & code_en;
      wire data_cls = c[`EBTT_EV_EN] & c[`EBTT_EV_DATA] & data_en;
      wire in_code = (insn_pc >= ev_lo[gi]) & (insn_pc <= ev_hi[gi]);
      wire in_data = (daddr >= ev_lo[gi]) & (daddr <= ev_hi[gi]);
      // effect type bits are independent, so one event may do several things
      assign code_brk[gi] = code_cls & c[`EBTT_EV_TYPE_A] & in_code;
      assign trace_hit[gi] = code_cls & c[`EBTT_EV_TYPE_B] & in_code;
      assign data_brk[gi] = data_cls & in_data &
        ((c[`EBTT_EV_TYPE_A] & (dmem_rd | dmem_wr)) |
         (c[`EBTT_EV_TYPE_B] & dmem_wr) |
         (c[`EBTT_EV_TYPE_C] & dmem_wr & value_match));
    end
  endgenerate

  wire code_hit = insn_valid & ~core_halt & (|code_brk);
  wire data_hit = (dmem_rd | dmem_wr) & (|data_brk);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      ext_lvl <= 1'b0;
      probe_s1 <= 8'h00;
      probe_s2 <= 8'h00;
      probe_s3 <= 8'h00;
    end else begin
      ext_s1 <= ext_break;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      // filtered level moves only once the last two stages agree
      if (ext_s2 == ext_s3) begin
        ext_lvl <= ext_s3;
      end
      probe_s1 <= probe;
      probe_s2 <= probe_s1;
      probe_s3 <= probe_s2;
    end
  end

  wire ext_settled = (ext_s2 == ext_s3);
  wire ext_rise = ext_settled & ext_s3 & ~ext_lvl;
  wire ext_fall = ext_settled & ~ext_s3 & ext_lvl;
  wire ext_hit = ctrl[`EBTT_CTRL_EXT_EN] &
    (ctrl[`EBTT_CTRL_EXT_RISE] ? ext_rise : ext_fall);

  ////////////////////////////////////////////////////////////////////////////
  // halt sources and halt state

  wire [`EBTT_CAUSE_W-1:0] cause_set;
  assign cause_set[`EBTT_CAUSE_CODE] = code_hit;
  assign cause_set[`EBTT_CAUSE_DATA] = data_hit;
  assign cause_set[`EBTT_CAUSE_EXT] = ext_hit;
  assign cause_set[`EBTT_CAUSE_WDT] = ctrl[`EBTT_CTRL_WDT_EN] & wdt_overflow;
  assign cause_set[`EBTT_CAUSE_TROVF] = ctrl[`EBTT_CTRL_TROVF_EN] & tr_overflow;
  assign cause_set[`EBTT_CAUSE_TIMER] =
    ctrl[`EBTT_CTRL_TIMER_EN] & free_running_timer_overflow;
  assign cause_set[`EBTT_CAUSE_STACK] =
    ctrl[`EBTT_CTRL_STACK_EN] & (stack_overflow | stack_underflow);
  assign cause_set[`EBTT_CAUSE_HOST] = host_halt;

  // a code break stops before its own instruction; every other source waits
  wire async_req = |cause_set[`EBTT_CAUSE_W-1:1];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
      core_halt <= 1'b0;
      halt_pc <= {PC_W{1'b0}};
      cause <= {`EBTT_CAUSE_W{1'b0}};
    end else begin
      // new causes win over a resume in the same cycle
      cause <= (resume ? {`EBTT_CAUSE_W{1'b0}} : cause) | cause_set;
      if (insn_valid & ~core_halt & (pending | code_hit)) begin
        core_halt <= 1'b1;
        halt_pc <= insn_pc;
        pending <= async_req;
      end else if (resume) begin
        core_halt <= 1'b0;
        pending <= async_req;
      end else if (async_req) begin
        pending <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trace capture

  // with conditional tracing off the ranges are ignored
  wire tr_take = ~ctrl[`EBTT_CTRL_COND_TRACE] | (|trace_hit);
  wire tr_wr = insn_valid & ~core_halt & ~code_hit & ~(pending) & tr_take;
  wire [3:0] tr_ctl = {ctrl[`EBTT_CTRL_COND_TRACE], ctrl[`EBTT_CTRL_PROBE_SEL], 2'b00};
  wire [7:0] tr_low = ctrl[`EBTT_CTRL_PROBE_SEL] ? probe_s3 : insn_dbus;
  wire [15:0] tr_pc = {{(16-PC_W){1'b0}}, insn_pc};
  wire [31:0] tr_rec = {tr_ctl | tr_pc[15:12], tr_pc[11:0], insn_alu, tr_low};

  ebtt_trace_buf #(
    .DEPTH(`EBTT_TRACE_DEPTH),
    .AW(`EBTT_TRACE_AW),
    .W(`EBTT_TRACE_W)
  ) u_trace (
    .clk(clk),
    .rst(rst),
    .wr_en(tr_wr),
    .wr_data(tr_rec),
    .clear(tr_clear),
    .rd_depth(tr_depth),
    .rd_data(tr_rdata),
    .count(tr_count),
    .overflow(tr_overflow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb writes

  wire [`EBTT_EV_CFG_W-1:0] sel_cfg = ev_cfg[ev_sel];
  wire [PC_W-1:0] sel_lo = ev_lo[ev_sel];
  wire [PC_W-1:0] sel_hi = ev_hi[ev_sel];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `EBTT_CTRL_RESET;
      ref_value <= 8'h00;
      ref_mask <= 8'h00;
      ev_sel <= {EV_SEL_W{1'b0}};
      tr_depth <= {{TAW{1'b0}}, 1'b1};
      for (k = 0; k < NUM_EVENTS; k = k + 1) begin
        ev_cfg[k] <= `EBTT_EV_CFG_RESET;
        ev_lo[k] <= {PC_W{1'b0}};
        ev_hi[k] <= {PC_W{1'b0}};
      end
    end else if (wr_acc) begin
      case (paddr)
        `EBTT_OFS_CTRL: ctrl <= pwdata[`EBTT_CTRL_W-1:0];
        `EBTT_OFS_VALUE: ref_value <= pwdata[7:0];
        `EBTT_OFS_MASK: ref_mask <= pwdata[7:0];
        `EBTT_OFS_EV_SEL: ev_sel <= pwdata[EV_SEL_W-1:0];
        `EBTT_OFS_EV_CFG: ev_cfg[ev_sel] <= pwdata[`EBTT_EV_CFG_W-1:0];
        `EBTT_OFS_EV_START: ev_lo[ev_sel] <= pwdata[PC_W-1:0];
        `EBTT_OFS_EV_END: ev_hi[ev_sel] <= pwdata[PC_W-1:0];
        `EBTT_OFS_TR_DEPTH: tr_depth <= pwdata[TAW:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // stack port: writes only reach the core while it is halted
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stk_index <= {STK_W{1'b0}};
      stk_wdata <= {PC_W{1'b0}};
      stk_we <= 1'b0;
      sp_wdata <= {STK_W{1'b0}};
      sp_we <= 1'b0;
    end else begin
      stk_we <= wr_acc & core_halt & (paddr == `EBTT_OFS_STK_DATA);
      sp_we <= wr_acc & core_halt & (paddr == `EBTT_OFS_SP);
      if (wr_acc & (paddr == `EBTT_OFS_STK_SEL)) begin
        stk_index <= pwdata[STK_W-1:0];
      end
      if (wr_acc & (paddr == `EBTT_OFS_STK_DATA)) begin
        stk_wdata <= pwdata[PC_W-1:0];
      end
      if (wr_acc & (paddr == `EBTT_OFS_SP)) begin
        sp_wdata <= pwdata[STK_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb reads, captured in the setup cycle

  reg [31:0] next_prdata;
  reg next_err;

  always @* begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      `EBTT_OFS_CTRL: next_prdata[`EBTT_CTRL_W-1:0] = ctrl;
      `EBTT_OFS_STATUS: next_prdata[`EBTT_CAUSE_W:0] = {cause, core_halt};
      `EBTT_OFS_VALUE: next_prdata[7:0] = ref_value;
      `EBTT_OFS_MASK: next_prdata[7:0] = ref_mask;
      `EBTT_OFS_EV_SEL: next_prdata[EV_SEL_W-1:0] = ev_sel;
      `EBTT_OFS_EV_CFG: next_prdata[`EBTT_EV_CFG_W-1:0] = sel_cfg;
      `EBTT_OFS_EV_START: next_prdata[PC_W-1:0] = sel_lo;
      `EBTT_OFS_EV_END: next_prdata[PC_W-1:0] = sel_hi;
      `EBTT_OFS_CMD: next_prdata = 32'h0000_0000;
      `EBTT_OFS_TR_DEPTH: next_prdata[TAW:0] = tr_depth;
      `EBTT_OFS_TR_DATA: next_prdata = tr_rdata;
      `EBTT_OFS_TR_COUNT: next_prdata[TAW:0] = tr_count;
      `EBTT_OFS_STK_SEL: next_prdata[STK_W-1:0] = stk_index;
      // live core values are only meaningful while halted
      `EBTT_OFS_STK_DATA: next_prdata[PC_W-1:0] = core_halt ? stk_rdata : {PC_W{1'b0}};
      `EBTT_OFS_SP: next_prdata[STK_W-1:0] = core_halt ? sp_rdata : {STK_W{1'b0}};
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_err;
    end
  end

endmodule // ebtt_trigger
`default_nettype wire

// File: ebtt_checker.sv
// port assertions of the break and trace trigger unit
`timescale 1ns/100ps
`default_nettype none
`include "ebtt_regs.vh"
module ebtt_checker #(
  parameter PC_W = 12,
  parameter STK_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire logic insn_valid,
  input wire logic [PC_W-1:0] insn_pc,
  input wire logic core_halt,
  input wire logic [PC_W-1:0] halt_pc,
  input wire logic stk_we,
  input wire logic sp_we
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr_acc = psel && penable && pwrite;
  wire logic resume_acc = wr_acc && paddr == `EBTT_OFS_CMD && pwdata[`EBTT_CMD_RESUME];
  wire logic stk_acc = wr_acc && paddr == `EBTT_OFS_STK_DATA && core_halt;
  wire logic sp_acc = wr_acc && paddr == `EBTT_OFS_SP && core_halt;
  wire logic stk_bad = wr_acc && paddr == `EBTT_OFS_STK_DATA && !core_halt;
  ////////////////////////////////////////////////////////////////
  sequence s_resume;
    resume_acc && core_halt;
  endsequence
  sequence s_idle2;
    !stk_we ##1 !stk_we;
  endsequence
  a_pready_tied: assert property (pready) else $error("pready low");
  a_halt_boundary: assert property ($rose(core_halt) |-> $past(insn_valid))
    else $error("halt off boundary");
  a_halt_pc_of: assert property ($rose(core_halt) |-> halt_pc == $past(insn_pc))
    else $error("halt pc wrong");
  a_halt_holds: assert property (core_halt && !resume_acc |=> core_halt)
    else $error("halt dropped");
  a_resume_fall: assert property (s_resume |=> !core_halt) else $error("resume ignored");
  a_pc_stable: assert property (core_halt && $past(core_halt) |-> $stable(halt_pc))
    else $error("halt pc moved");
  a_err_unmapped: assert property (psel && penable && paddr > `EBTT_OFS_SP |-> pslverr)
    else $error("no error on unmapped");
  a_err_mapped: assert property (psel && penable && paddr <= `EBTT_OFS_SP && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("error on mapped");
  a_stk_write: assert property (stk_we |-> $past(stk_acc) || $past(stk_acc, 2))
    else $error("stray stack write");
  a_sp_write: assert property (sp_we |-> $past(sp_acc) || $past(sp_acc, 2))
    else $error("stray sp write");
  a_stk_ignored: assert property (stk_bad |=> s_idle2) else $error("stack write running");
endmodule // ebtt_checker
bind ebtt_trigger ebtt_checker #(.PC_W(PC_W), .STK_W(STK_W)) u_ebtt_checker (.clk, .rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .insn_valid, .insn_pc,
  .core_halt, .halt_pc, .stk_we, .sp_we);
`default_nettype wire

// File: ebtt_core_model.sv
// behavioural emulated core: one instruction every four clocks, return stack
`timescale 1ns/100ps
`default_nettype none
module ebtt_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction and data side
  input wire logic core_halt,
  output logic insn_valid,
  output logic [11:0] insn_pc,
  output logic [7:0] insn_alu,
  output logic [7:0] insn_dbus,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [7:0] dmem_addr,
  output logic [7:0] dmem_wdata,
  // return stack
  input wire logic [2:0] stk_index,
  output logic [11:0] stk_rdata,
  input wire logic [11:0] stk_wdata,
  input wire logic stk_we,
  output logic [2:0] sp_rdata,
  input wire logic [2:0] sp_wdata,
  input wire logic sp_we
);
  logic [1:0] ph;
  logic [3:0] pc, xp;
  logic iss;
  logic [11:0] stk [8];
  assign insn_pc = {8'h00, pc};
  assign insn_alu = {4'h5, pc};
  assign insn_dbus = {4'hC, pc};
  assign dmem_addr = {4'h4, xp};
  assign dmem_wdata = {4'hA, xp};
  assign stk_rdata = stk[stk_index];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 2'h0;
      pc <= 4'h0;
      xp <= 4'h0;
      iss <= 1'b0;
      insn_valid <= 1'b0;
      dmem_rd <= 1'b0;
      dmem_wr <= 1'b0;
      sp_rdata <= 3'h0;
    end else begin
      ph <= ph + 2'h1;
      insn_valid <= ph == 2'h0 && !core_halt;
      if (ph == 2'h0) iss <= !core_halt;
      dmem_rd <= 1'b0;
      dmem_wr <= 1'b0;
      // a halted instruction is not executed, so the pc stays on it
      if (ph == 2'h2 && iss && !core_halt) begin
        pc <= pc + 4'h1;
        xp <= pc;
        dmem_wr <= pc[0];
        dmem_rd <= !pc[0];
      end
      if (stk_we) stk[stk_index] <= stk_wdata;
      if (sp_we) sp_rdata <= sp_wdata;
    end
  end
endmodule // ebtt_core_model
`default_nettype wire

// File: ebtt_tb.sv
// self-checking bench of the break and trace trigger unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, erv;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdv;
  logic wdt_overflow = 1'b0, free_running_timer_overflow = 1'b0, ext_break = 1'b0;
  logic stack_overflow = 1'b0, stack_underflow = 1'b0;
  logic [7:0] probe = 8'h00;
  logic [3:0] p;
  wire logic pready, pslverr, core_halt, insn_valid, dmem_rd, dmem_wr, stk_we, sp_we;
  wire logic [31:0] prdata;
  wire logic [11:0] halt_pc, insn_pc, stk_rdata, stk_wdata;
  wire logic [7:0] insn_alu, insn_dbus, dmem_addr, dmem_wdata;
  wire logic [2:0] stk_index, sp_rdata, sp_wdata;
  int errors = 0, checks_done = 0, cyc = 0;
  logic [7:0] ecfg [3] = '{8'h0D, 8'h07, 8'h13};
  logic [7:0] elo [3] = '{8'h05, 8'h46, 8'h40};
  logic [7:0] ehi [3] = '{8'h05, 8'h46, 8'h4F};
  logic [9:0] ictl [6] = '{10'h020, 10'h080, 10'h100, 10'h100, 10'h018, 10'h008};
  logic [31:0] ist [6] = '{32'h11, 32'h41, 32'h81, 32'h81, 32'h09, 32'h09};
  ebtt_trigger u_ebtt_trigger (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .insn_valid, .insn_pc, .insn_alu, .insn_dbus, .dmem_rd,
    .dmem_wr, .dmem_addr, .dmem_wdata, .wdt_overflow, .free_running_timer_overflow,
    .stack_overflow, .stack_underflow, .ext_break, .probe, .core_halt, .halt_pc,
    .stk_index, .stk_rdata, .stk_wdata, .stk_we, .sp_rdata, .sp_wdata, .sp_we);
  ebtt_core_model u_ebtt_core_model (.clk, .rst, .core_halt, .insn_valid, .insn_pc,
    .insn_alu, .insn_dbus, .dmem_rd, .dmem_wr, .dmem_addr, .dmem_wdata, .stk_index,
    .stk_rdata, .stk_wdata, .stk_we, .sp_rdata, .sp_wdata, .sp_we);
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, then an idle cycle so the next setup never collides
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task automatic wait_halt;
    int n;
    n = 0;
    while (core_halt !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, core_halt}, 32'h1);
  endtask
  task automatic halt_at(input logic [11:0] pc);
    wait_halt;
    chk({20'h0, halt_pc}, {20'h0, pc});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 32'h0);
    rd(8'h24, 32'h1);
    rd(8'h3C, 32'h0);
    chk({31'h0, erv}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h10, i);
      wr(8'h14, {24'h0, ecfg[i]});
      wr(8'h18, {24'h0, elo[i]});
      wr(8'h1C, {24'h0, ehi[i]});
    end
    rd(8'h14, 32'h13);
    rd(8'h1C, 32'h4F);
    wr(8'h08, 32'hAD);
    wr(8'h0C, 32'h0F);
    rd(8'h08, 32'hAD);
    rd(8'h0C, 32'h0F);
    wdt_overflow <= 1'b1;
    @(posedge clk);
    wdt_overflow <= 1'b0;
    repeat (80) @(posedge clk);
    chk({31'h0, core_halt}, 32'h0);
    $display("test gating done");
    wr(8'h00, 32'h1);
    halt_at(12'h005);
    rd(8'h04, 32'h3);
    wr(8'h10, 32'h0);
    wr(8'h18, 32'h9);
    wr(8'h1C, 32'h9);
    wr(8'h20, 32'h1);
    halt_at(12'h009);
    for (int d = 1; d <= 3; d++) begin
      wr(8'h24, d);
      repeat (2) @(posedge clk);
      p = 4'(9 - d);
      rd(8'h28, {12'h000, p, 4'h5, p, 4'hC, p});
    end
    wr(8'h30, 32'h2);
    wr(8'h34, 32'h123);
    rd(8'h34, 32'h123);
    wr(8'h38, 32'h5);
    rd(8'h38, 32'h5);
    $display("test code done");
    wr(8'h00, 32'h2);
    wr(8'h20, 32'h1);
    halt_at(12'h00E);
    rd(8'h04, 32'h5);
    wr(8'h20, 32'h1);
    halt_at(12'h007);
    rd(8'h04, 32'h5);
    $display("test data done");
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, {22'h0, ictl[i]});
      wr(8'h20, 32'h1);
      case (i)
        0: wdt_overflow <= 1'b1;
        1: free_running_timer_overflow <= 1'b1;
        2: stack_overflow <= 1'b1;
        3: stack_underflow <= 1'b1;
        default: ext_break <= i == 4;
      endcase
      @(posedge clk);
      {wdt_overflow, free_running_timer_overflow, stack_overflow, stack_underflow} <= 4'h0;
      wait_halt;
      rd(8'h04, ist[i]);
    end
    $display("test internal done");
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h1);
    wr(8'h34, 32'h456);
    rd(8'h34, 32'h0);
    wr(8'h20, 32'h2);
    wait_halt;
    rd(8'h04, 32'h101);
    rd(8'h34, 32'h123);
    $display("test host done");
    // park on the code break at 9 so the trace test starts from a known pc
    probe <= 8'h3C;
    wr(8'h00, 32'h1);
    wr(8'h20, 32'h1);
    halt_at(12'h009);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h09);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h0B);
    wr(8'h00, 32'h207);
    wr(8'h24, 32'h1);
    wr(8'h20, 32'h5);
    halt_at(12'h00A);
    rd(8'h04, 32'h5);
    rd(8'h2C, 32'h1);
    rd(8'h28, 32'hC009_593C);
    $display("test trace points done");
    // filling 4096 records at one per four clocks takes a long wait
    wr(8'h00, 32'h40);
    wr(8'h20, 32'h5);
    repeat (16300) @(posedge clk);
    wait_halt;
    rd(8'h04, 32'h21);
    rd(8'h2C, 32'h1000);
    $display("test trace overflow done");
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
